// ==== common/cgo_pkg.sv ====
// Register map, field layout and reset values of the clock generator
package cgo_pkg;

   // Register byte offsets, decoded from haddr[7:0]
   localparam logic [7:0] SYS_CTRL_OFS  = 8'h00;
   localparam logic [7:0] OSC_CTRL_OFS  = 8'h04;
   localparam logic [7:0] STBY_CTRL_OFS = 8'h08;
   localparam logic [7:0] PLL_SEL_OFS   = 8'h0c;
   localparam logic [7:0] IRQ_STAT_OFS  = 8'h20;
   localparam logic [7:0] IRQ_MASK_OFS  = 8'h24;

   // System clock control fields
   localparam int SYS_GEAR_LSB   = 0;
   localparam int SYS_PRESC_LSB  = 8;
   localparam int SYS_PSRC_BIT   = 12;
   localparam int SYS_FIXED_LSB  = 16;
   localparam logic [2:0] GEAR_RST     = 3'h0;
   localparam logic [2:0] PRESC_RST    = 3'h0;
   localparam logic       PSRC_RST     = 1'b0;
   localparam logic [1:0] SYS_FIXED_RST = 2'h1;

   // Oscillator control fields
   localparam int OSC_KICK_BIT   = 0;
   localparam int OSC_WUACT_BIT  = 1;
   localparam int OSC_PLL_BIT    = 2;
   localparam int OSC_WUAUX_BIT  = 3;
   localparam int OSC_XEXT_BIT   = 8;
   localparam int OSC_XINT_BIT   = 16;
   localparam int OSC_HSSEL_BIT  = 17;
   localparam int OSC_CLAIM_BIT  = 18;
   localparam int OSC_WUSRC_BIT  = 19;
   localparam int OSC_WUCNT_LSB  = 20;
   localparam int WUCNT_W        = 12;
   localparam logic [11:0] WUCNT_RST = 12'h800;
   localparam logic PLL_RST      = 1'b0;
   localparam logic WUAUX_RST    = 1'b0;
   localparam logic XEXT_RST     = 1'b0;
   localparam logic XINT_RST     = 1'b1;
   localparam logic HSSEL_RST    = 1'b0;
   localparam logic CLAIM_RST    = 1'b0;
   localparam logic WUSRC_RST    = 1'b0;

   // Interrupt status and mask layout
   localparam int IRQ_W          = 2;
   localparam int IRQ_WU_DONE    = 0;
   localparam int IRQ_WU_RESTART = 1;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;

   // Gear and prescaler codes
   localparam logic [2:0] GEAR_DIV1  = 3'h0;
   localparam logic [2:0] GEAR_DIV2  = 3'h4;
   localparam logic [2:0] GEAR_DIV4  = 3'h5;
   localparam logic [2:0] GEAR_DIV8  = 3'h6;
   localparam logic [2:0] GEAR_DIV16 = 3'h7;
   localparam logic [2:0] PRESC_MAX  = 3'h5;
   localparam int DIV_CNT_W          = 5;

   // AHB transfer encoding
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage : cgo_pkg

// ==== src/cgo_top.sv ====
// Clock generator and oscillator control with AHB-Lite register slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Peripheral clock follows geared clock when source bit is 0, high-speed clock when 1.
// - Prescaler clock divides peripheral clock by 1..32 for codes 000..101.
// - Gear field divides high-speed clock: 000 none, 100..111 by 2,4,8,16.
// - Twelve-bit warm-up count value sits in oscillator control bits 31 to 20.
// - Warm-up timer counts internal oscillator at 0, external oscillator at 1.
// - Pin-claim bit hands shared pins to the crystal when set; resets to 0.
// - Oscillator select bit picks internal (0) or external (1) high-speed source.
// - Internal oscillator runs while its enable is 1; enable resets to 1.
// - External oscillator runs while its enable is 1; enable resets to 0.
// - PLL stays stopped after reset and runs only while its run bit is 1.
// - Writing 1 to the kick bit starts warm-up; 0 does nothing; write-only.
// - Warm-up status reads 1 while counting and 0 once complete.

module cgo_top
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Raw oscillator outputs, asynchronous to ref_clk
   input  wire logic        int_osc_in,
   input  wire logic        ext_osc_in,
   // Oscillator, PLL and pin control
   output logic             int_osc_enable,
   output logic             ext_osc_enable,
   output logic             pll_run,
   output logic             hs_osc_select,
   output logic             osc_pin_claim,
   output logic             warmup_src_sel,
   // Clock enables derived from the high-speed clock
   output logic             gear_ce,
   output logic             periph_ce,
   output logic             presc_ce,
   // Interrupt
   output logic             irq
);

   // Divider select: shift count to an all-ones compare mask
   function automatic logic [4:0] div_mask(input logic [2:0] shift);
      div_mask = 5'((6'h01 << shift) - 6'h01);
   endfunction : div_mask

   // Gear code to shift; reserved codes run undivided
   function automatic logic [2:0] gear_shift(input logic [2:0] code);
      unique case (code)
         cgo_pkg::GEAR_DIV2:  gear_shift = 3'h1;
         cgo_pkg::GEAR_DIV4:  gear_shift = 3'h2;
         cgo_pkg::GEAR_DIV8:  gear_shift = 3'h3;
         cgo_pkg::GEAR_DIV16: gear_shift = 3'h4;
         default:             gear_shift = 3'h0;
      endcase
   endfunction : gear_shift

   // Register state
   logic [2:0]  gear_reg;
   logic [2:0]  prescale_sel_reg;
   logic        periph_src_sel_reg;
   logic [1:0]  sys_fixed_reg;
   logic [11:0] warmup_count_value_reg;
   logic        warmup_src_sel_reg;
   logic        osc_pin_claim_reg;
   logic        hs_osc_select_reg;
   logic        int_osc_enable_reg;
   logic        ext_osc_enable_reg;
   logic        warmup_src_aux_reg;
   logic        pll_run_reg;
   logic        warmup_active_reg;
   logic [11:0] warmup_cnt_reg;
   logic [1:0]  irq_stat_reg;
   logic [1:0]  irq_mask_reg;
   logic [4:0]  gear_cnt_reg;
   logic [4:0]  presc_cnt_reg;
   logic [31:0] hrdata_reg;

   // Bus data-phase state
   logic        dp_write_reg;
   logic [7:0]  dp_addr_reg;

   // Oscillator synchronisers and edge detect
   logic [1:0]  int_sync_reg;
   logic [1:0]  ext_sync_reg;
   logic        int_prev_reg;
   logic        ext_prev_reg;

   // Address phase decode
   wire         ap_valid  = hsel && hready && (htrans == cgo_pkg::HTRANS_NONSEQ);
   wire         ap_word   = (hsize == cgo_pkg::HSIZE_WORD);
   wire         ap_write  = ap_valid && hwrite && ap_word;
   wire         ap_read   = ap_valid && !hwrite;
   wire [7:0]   ap_addr   = haddr[7:0];
   wire         ap_inmap  = (haddr[31:8] == 24'h000000);

   // Data phase write strobes
   wire         wr_sys    = dp_write_reg && (dp_addr_reg == cgo_pkg::SYS_CTRL_OFS);
   wire         wr_osc    = dp_write_reg && (dp_addr_reg == cgo_pkg::OSC_CTRL_OFS);
   wire         wr_stat   = dp_write_reg && (dp_addr_reg == cgo_pkg::IRQ_STAT_OFS);
   wire         wr_mask   = dp_write_reg && (dp_addr_reg == cgo_pkg::IRQ_MASK_OFS);
   wire         kick_req  = wr_osc && hwdata[cgo_pkg::OSC_KICK_BIT];

   // Read images; reserved bits are zero
   wire [31:0]  sys_image = {14'h0000, sys_fixed_reg, 3'h0, periph_src_sel_reg,
                             1'b0, prescale_sel_reg, 5'h00, gear_reg};
   wire [31:0]  osc_image = {warmup_count_value_reg, warmup_src_sel_reg,
                             osc_pin_claim_reg, hs_osc_select_reg, int_osc_enable_reg,
                             7'h00, ext_osc_enable_reg, 4'h0, warmup_src_aux_reg,
                             pll_run_reg, warmup_active_reg, 1'b0};
   wire [31:0]  rd_mux    = (!ap_inmap)                               ? 32'h00000000 :
                            (ap_addr == cgo_pkg::SYS_CTRL_OFS)        ? sys_image :
                            (ap_addr == cgo_pkg::OSC_CTRL_OFS)        ? osc_image :
                            (ap_addr == cgo_pkg::IRQ_STAT_OFS)        ? {30'h0, irq_stat_reg} :
                            (ap_addr == cgo_pkg::IRQ_MASK_OFS)        ? {30'h0, irq_mask_reg} :
                                                                        32'h00000000;

   // Clock dividers; the high-speed clock is ref_clk itself
   wire [4:0]   gear_msk  = div_mask(gear_shift(gear_reg));
   wire [2:0]   presc_sh  = (prescale_sel_reg > cgo_pkg::PRESC_MAX) ? 3'h0 : prescale_sel_reg;
   wire [4:0]   presc_msk = div_mask(presc_sh);
   wire         gear_tick = ((gear_cnt_reg & gear_msk) == gear_msk);
   wire         per_tick  = periph_src_sel_reg ? 1'b1 : gear_tick;
   wire         pre_tick  = per_tick && ((presc_cnt_reg & presc_msk) == presc_msk);

   // Warm-up source edge from the synchronised oscillators
   wire         int_edge  = int_sync_reg[1] && !int_prev_reg;
   wire         ext_edge  = ext_sync_reg[1] && !ext_prev_reg;
   wire         wu_edge   = warmup_src_sel_reg ? ext_edge : int_edge;
   wire         wu_hit    = warmup_active_reg && (warmup_cnt_reg == warmup_count_value_reg);
   wire [1:0]   irq_set   = {kick_req && warmup_active_reg, wu_hit};
   wire [1:0]   irq_clr   = wr_stat ? hwdata[1:0] : 2'h0;

   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign hrdata         = hrdata_reg;
   assign int_osc_enable = int_osc_enable_reg;
   assign ext_osc_enable = ext_osc_enable_reg;
   assign pll_run        = pll_run_reg;
   assign hs_osc_select  = hs_osc_select_reg;
   assign osc_pin_claim  = osc_pin_claim_reg;
   assign warmup_src_sel = warmup_src_sel_reg;
   assign gear_ce        = gear_tick;
   assign periph_ce      = per_tick;
   assign presc_ce       = pre_tick;
   assign irq            = |(irq_stat_reg & irq_mask_reg);

   // Bus slave: zero wait states, read data captured in the address phase
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         dp_write_reg <= 1'b0;
         dp_addr_reg  <= 8'h00;
         hrdata_reg   <= 32'h00000000;
      end
      else
      begin
         dp_write_reg <= ap_write && ap_inmap;
         dp_addr_reg  <= ap_addr;
         if (ap_read)
            hrdata_reg <= rd_mux;
      end
   end

   // System clock control register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         gear_reg           <= cgo_pkg::GEAR_RST;
         prescale_sel_reg   <= cgo_pkg::PRESC_RST;
         periph_src_sel_reg <= cgo_pkg::PSRC_RST;
         sys_fixed_reg      <= cgo_pkg::SYS_FIXED_RST;
      end
      else if (wr_sys)
      begin
         gear_reg           <= hwdata[cgo_pkg::SYS_GEAR_LSB +: 3];
         prescale_sel_reg   <= hwdata[cgo_pkg::SYS_PRESC_LSB +: 3];
         periph_src_sel_reg <= hwdata[cgo_pkg::SYS_PSRC_BIT];
         sys_fixed_reg      <= hwdata[cgo_pkg::SYS_FIXED_LSB +: 2];
      end
   end

   // Oscillator control register
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         warmup_count_value_reg <= cgo_pkg::WUCNT_RST;
         warmup_src_sel_reg     <= cgo_pkg::WUSRC_RST;
         osc_pin_claim_reg      <= cgo_pkg::CLAIM_RST;
         hs_osc_select_reg      <= cgo_pkg::HSSEL_RST;
         int_osc_enable_reg     <= cgo_pkg::XINT_RST;
         ext_osc_enable_reg     <= cgo_pkg::XEXT_RST;
         warmup_src_aux_reg     <= cgo_pkg::WUAUX_RST;
         pll_run_reg            <= cgo_pkg::PLL_RST;
      end
      else if (wr_osc)
      begin
         warmup_count_value_reg <= hwdata[cgo_pkg::OSC_WUCNT_LSB +: cgo_pkg::WUCNT_W];
         warmup_src_sel_reg     <= hwdata[cgo_pkg::OSC_WUSRC_BIT];
         osc_pin_claim_reg      <= hwdata[cgo_pkg::OSC_CLAIM_BIT];
         hs_osc_select_reg      <= hwdata[cgo_pkg::OSC_HSSEL_BIT];
         int_osc_enable_reg     <= hwdata[cgo_pkg::OSC_XINT_BIT];
         ext_osc_enable_reg     <= hwdata[cgo_pkg::OSC_XEXT_BIT];
         warmup_src_aux_reg     <= hwdata[cgo_pkg::OSC_WUAUX_BIT];
         pll_run_reg            <= hwdata[cgo_pkg::OSC_PLL_BIT];
      end
   end

   // Oscillator synchronisers: second stage feeds the edge detector
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         int_sync_reg <= 2'h0;
         ext_sync_reg <= 2'h0;
         int_prev_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end
      else
      begin
         int_sync_reg <= {int_sync_reg[0], int_osc_in};
         ext_sync_reg <= {ext_sync_reg[0], ext_osc_in};
         int_prev_reg <= int_sync_reg[1];
         ext_prev_reg <= ext_sync_reg[1];
      end
   end

   // Warm-up timer; a kick while counting restarts from zero
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         warmup_active_reg <= 1'b0;
         warmup_cnt_reg    <= 12'h000;
      end
      else if (kick_req)
      begin
         warmup_active_reg <= 1'b1;
         warmup_cnt_reg    <= 12'h000;
      end
      else if (wu_hit)
         warmup_active_reg <= 1'b0;
      else if (warmup_active_reg && wu_edge)
         warmup_cnt_reg <= warmup_cnt_reg + 12'h001;
   end

   // Interrupt status (write one to clear, set wins) and mask
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_stat_reg <= 2'h0;
         irq_mask_reg <= cgo_pkg::IRQ_MASK_RST;
      end
      else
      begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         if (wr_mask)
            irq_mask_reg <= hwdata[1:0];
      end
   end

   // Divider counters; the prescaler advances only on peripheral ticks
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         gear_cnt_reg  <= 5'h00;
         presc_cnt_reg <= 5'h00;
      end
      else
      begin
         gear_cnt_reg <= gear_cnt_reg + 5'h01;
         if (per_tick)
            presc_cnt_reg <= presc_cnt_reg + 5'h01;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   periph_fast_a: assert property (
      periph_src_sel_reg |-> periph_ce)
      else $error("peripheral enable low while fed from the high-speed clock");

   periph_gear_a: assert property (
      !periph_src_sel_reg |-> (periph_ce == gear_ce))
      else $error("peripheral enable differs from geared enable");

   presc_pass_a: assert property (
      (prescale_sel_reg == 3'h0) |-> (presc_ce == periph_ce))
      else $error("undivided prescaler does not follow peripheral enable");

   gear_half_a: assert property (
      (gear_reg == cgo_pkg::GEAR_DIV2 && !wr_sys && gear_ce) |=> !gear_ce)
      else $error("halved gear enable high in two consecutive cycles");

   gear_full_a: assert property (
      (gear_reg == cgo_pkg::GEAR_DIV1) |-> gear_ce)
      else $error("undivided gear enable not high");

   osc_write_a: assert property (
      wr_osc |=> (int_osc_enable == $past(hwdata[16])) && (ext_osc_enable == $past(hwdata[8]))
                 && (pll_run == $past(hwdata[2])) && (hs_osc_select == $past(hwdata[17]))
                 && (osc_pin_claim == $past(hwdata[18])))
      else $error("oscillator control outputs do not follow the write");

   warmup_start_a: assert property (
      kick_req |=> warmup_active_reg && (warmup_cnt_reg == 12'h000))
      else $error("warm-up did not start on a kick");

   warmup_src_a: assert property (
      warmup_active_reg && !kick_req && !wu_hit && wu_edge
      |=> warmup_cnt_reg == $past(warmup_cnt_reg) + 12'h001)
      else $error("warm-up count did not advance on a source edge");

   warmup_end_a: assert property (
      wu_hit && !kick_req |=> !warmup_active_reg && irq_stat_reg[cgo_pkg::IRQ_WU_DONE])
      else $error("warm-up did not complete at the count value");

   reserved_zero_a: assert property (
      ap_read && ap_inmap && (ap_addr == cgo_pkg::SYS_CTRL_OFS)
      |=> (hrdata[31:18] == 14'h0000) && (hrdata[15:13] == 3'h0) && (hrdata[7:3] == 5'h00))
      else $error("reserved system control bits read non-zero");

   set_wins_a: assert property (
      wu_hit && wr_stat && hwdata[cgo_pkg::IRQ_WU_DONE] |=> irq_stat_reg[cgo_pkg::IRQ_WU_DONE])
      else $error("warm-up event lost against a clear");

   warmup_done_c: cover property (warmup_active_reg ##1 !warmup_active_reg);
   ext_select_c:  cover property ($rose(hs_osc_select));
   presc_max_c:   cover property ((prescale_sel_reg == cgo_pkg::PRESC_MAX) && presc_ce);
   irq_raise_c:   cover property ($rose(irq));

endmodule : cgo_top

// ==== test/clock_gen_osc_control_tb.sv ====
// Self-checking testbench of the clock generator registers, dividers and warm-up timer
`timescale 1ns/1ps
module clock_gen_osc_control_tb;
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0000_0000;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [2:0]  hsize   = 3'h2;
   logic [31:0] hwdata  = 32'h0000_0000;
   logic        int_osc_in = 1'b0;
   logic        ext_osc_in = 1'b0;
   logic        run_int    = 1'b0;
   logic        run_ext    = 1'b0;
   logic        hreadyout, hresp, irq, int_osc_enable, ext_osc_enable, pll_run;
   logic        hs_osc_select, osc_pin_claim, warmup_src_sel, gear_ce, periph_ce, presc_ce;
   logic [31:0] hrdata, rd;
   logic [31:0] sys_m, osc_m, stat_m, mask_m;
   int          errors   = 0;
   int          compares = 0;
   int          seed     = 32'hee0c26b5;
   int          cyc      = 0;
   int          t0;

   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;

   // Oscillator stand-ins, four ref_clk cycles per period, silent when stopped
   always
   begin
      repeat (2) @(posedge ref_clk);
      if (run_int) int_osc_in <= ~int_osc_in;
      if (run_ext) ext_osc_in <= ~ext_osc_in;
   end

   cgo_top dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .int_osc_in(int_osc_in),
      .ext_osc_in(ext_osc_in), .int_osc_enable(int_osc_enable),
      .ext_osc_enable(ext_osc_enable), .pll_run(pll_run), .hs_osc_select(hs_osc_select),
      .osc_pin_claim(osc_pin_claim), .warmup_src_sel(warmup_src_sel), .gear_ce(gear_ce),
      .periph_ce(periph_ce), .presc_ce(presc_ce), .irq(irq));

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One single transfer; signals held until hready is sampled high
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      input logic [2:0] sz, output logic [31:0] r);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= cgo_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, cgo_pkg::HSIZE_WORD, x);
      case (a)
         32'h0:   sys_m = d & 32'h0003_1707;
         32'h4:   osc_m = d & 32'hffff_010c;
         32'h20:  stat_m = stat_m & ~d;
         32'h24:  mask_m = d & 32'h3;
         default: ;
      endcase
   endtask : wr

   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, cgo_pkg::HSIZE_WORD, rd);
      chk(rd, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask : rchk

   // Outputs settle after the edge that ends the write, so look mid-cycle
   task automatic chk_outs;
      @(negedge ref_clk);
      chk({26'h0, int_osc_enable, ext_osc_enable, pll_run, hs_osc_select, osc_pin_claim,
           warmup_src_sel}, {26'h0, osc_m[16], osc_m[8], osc_m[2], osc_m[17], osc_m[18],
           osc_m[19]});
   endtask : chk_outs

   task automatic chk_irq;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk({31'h0, irq}, {31'h0, |(stat_m & mask_m)});
   endtask : chk_irq

   // Polls the busy flag under a bound, then books the done event in the model
   task automatic wait_done;
      int n;
      n = 0;
      do
      begin
         bus(1'b0, 32'h4, 32'h0, cgo_pkg::HSIZE_WORD, rd);
         n++;
      end
      while (rd[1] !== 1'b0 && n < 400);
      chk({31'h0, rd[1]}, 32'h0);
      stat_m = stat_m | 32'h1;
   endtask : wait_done

   // Pulse counts over a window that is a multiple of every divide ratio
   task automatic div_run(input int g, input int p, input int s);
      int gd, pd, cg, cp, cq;
      gd = (g >= 4) ? (1 << (g - 3)) : 1;
      pd = (p <= 5) ? (1 << p) : 1;
      wr(32'h0, ($random(seed) & 32'hfffc_e8f8) | 32'h0001_0000 | (s << 12) | (p << 8) | g);
      rchk(32'h0, sys_m);
      repeat (512) @(posedge ref_clk);
      cg = 0;
      cp = 0;
      cq = 0;
      repeat (512)
      begin
         @(negedge ref_clk);
         cg += (gear_ce === 1'b1);
         cp += (periph_ce === 1'b1);
         cq += (presc_ce === 1'b1);
      end
      chk(cg, 512 / gd);
      chk(cp, s ? 512 : 512 / gd);
      chk(cq, 512 / ((s ? 1 : gd) * pd));
   endtask : div_run

   initial
   begin
      repeat (90000) @(posedge ref_clk);
      errors++;
      finish_test;
   end

   initial
   begin
      sys_m = 32'h0001_0000;
      osc_m = 32'h8001_0000;
      stat_m = 32'h0;
      mask_m = 32'h0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      chk_outs;
      rchk(32'h0, sys_m);
      rchk(32'h4, osc_m);
      rchk(32'h20, 32'h0);
      rchk(32'h24, 32'h0);
      // Unmapped, unmodelled and narrow accesses leave nothing behind
      wr(32'h8, 32'hffff_ffff);
      wr(32'h100, 32'hffff_ffff);
      bus(1'b1, 32'h0, 32'h0001_1707, 3'h0, rd);
      rchk(32'h8, 32'h0);
      rchk(32'hc, 32'h0);
      rchk(32'h10, 32'h0);
      rchk(32'h100, 32'h0);
      rchk(32'h0, sys_m);
      repeat (6)
      begin
         wr(32'h4, $random(seed) & 32'hfffd_0104);
         chk_outs;
         rchk(32'h4, osc_m);
      end
      for (int g = 0; g < 8; g++)
         for (int p = 0; p < 8; p++)
            div_run(g, p, $random(seed) & 1);
      // Warm-up from the internal source, done event raises the interrupt
      wr(32'h24, 32'h1);
      run_int <= 1'b1;
      wr(32'h4, 32'h0031_0000);
      wr(32'h4, 32'h0031_0000);
      t0 = cyc;
      wr(32'h4, 32'h0031_0001);
      rchk(32'h4, osc_m | 32'h2);
      wait_done;
      chk(cyc - t0 >= 8, 32'h1);
      rchk(32'h20, stat_m);
      chk_irq;
      wr(32'h24, 32'h2);
      chk_irq;
      // Restart while busy, then a zero count finishes at once
      wr(32'h4, 32'hfff1_0001);
      wr(32'h4, 32'hfff1_0001);
      stat_m = stat_m | 32'h2;
      chk_irq;
      rchk(32'h4, osc_m | 32'h2);
      wr(32'h4, 32'h0001_0001);
      wait_done;
      rchk(32'h20, 32'h3);
      wr(32'h20, 32'h3);
      rchk(32'h20, 32'h0);
      chk_irq;
      // External source selected while only the internal one toggles
      wr(32'h24, 32'h1);
      wr(32'h4, 32'h0029_0100);
      wr(32'h4, 32'h0029_0101);
      repeat (40) @(posedge ref_clk);
      rchk(32'h4, osc_m | 32'h2);
      run_ext <= 1'b1;
      wait_done;
      chk_irq;
      wr(32'h20, 32'h1);
      chk_irq;
      // Switch to the external oscillator, then stop the internal one
      wr(32'h4, osc_m | 32'h0002_0000);
      rchk(32'h4, osc_m);
      wr(32'h4, osc_m & ~32'h0001_0000);
      chk_outs;
      finish_test;
   end
endmodule : clock_gen_osc_control_tb
